/* File: design/ipf_map.vh */
// Contract
// - each 3-bit field is a binary level: 111 is level 7 (top), 001 level 1
// - adc1 done priority sits in bits 6:4 of register two; 000 disables it
// - change notify priority sits in bits 14:12 of register three, same code
// - register three holds i2c1 master/slave fields; bits 15,11:8,7,3 read zero
`ifndef IPF_MAP_VH
`define IPF_MAP_VH

// ------------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------------
`define IPF_ADDR_W        8
`define IPF_OFF_PRI_TWO   8'h00
`define IPF_OFF_PRI_THREE 8'h04
`define IPF_OFF_STATUS    8'h08

// ------------------------------------------------------------------
// field positions (low bit of each field; the status enable field is 5 bits wide)
// ------------------------------------------------------------------
`define IPF_UART1_TX_LSB  0
`define IPF_ADC1_DONE_LSB 4
`define IPF_I2C1_SLV_LSB  0
`define IPF_I2C1_MST_LSB  4
`define IPF_CHG_NOTE_LSB  12
`define IPF_STAT_EN_LSB   0
`define IPF_STAT_SRC_LSB  8
`define IPF_STAT_LVL_LSB  12
`define IPF_STAT_REQ_BIT  15

// ------------------------------------------------------------------
// reset values and level codes
// ------------------------------------------------------------------
`define IPF_PRI_RESET     3'h4
`define IPF_LVL_OFF       3'h0
`define IPF_LVL_TOP       3'h7
`define IPF_HSIZE_WORD    3'h2

// ------------------------------------------------------------------
// source indices
// ------------------------------------------------------------------
`define IPF_SRC_ADC1      3'h0
`define IPF_SRC_UART1_TX  3'h1
`define IPF_SRC_CHG_NOTE  3'h2
`define IPF_SRC_I2C1_MST  3'h3
`define IPF_SRC_I2C1_SLV  3'h4

`endif

/* File: design/ipf_ahb_slave.v */
`timescale 1ns/1ps
`include "ipf_map.vh"

module ipf_ahb_slave (
  input  wire                   ref_clk,
  input  wire                   rst,
  input  wire                   hsel,
  input  wire [31:0]            haddr,
  input  wire [1:0]             htrans,
  input  wire                   hwrite,
  input  wire [2:0]             hsize,
  input  wire                   hready,
  input  wire [31:0]            hwdata,
  input  wire [15:0]            regRdData,
  output reg                    hreadyout,
  output reg                    hresp,
  output reg  [31:0]            hrdata,
  output wire                   regWrEn,
  output wire [`IPF_ADDR_W-1:0] regAddr,
  output wire [15:0]            regWrData
);

  // ------------------------------------------------------------------
  // address phase capture
  // ------------------------------------------------------------------
  reg [`IPF_ADDR_W-1:0] addr_q;
  reg                   wrPend_q;
  reg                   rdPend_q;
  wire                  addrPhase;

  assign addrPhase = hsel & htrans[1] & hready;
  assign regWrEn   = wrPend_q;
  assign regAddr   = addr_q;
  assign regWrData = hwdata[15:0];

  // reads take one wait state so a read right behind a write sees new data
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      addr_q    <= 8'h00;
      wrPend_q  <= 1'b0;
      rdPend_q  <= 1'b0;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      hrdata    <= 32'h00000000;
    end else begin
      hresp <= 1'b0;
      if (rdPend_q) begin
        hrdata    <= {16'h0000, regRdData};
        hreadyout <= 1'b1;
        rdPend_q  <= 1'b0;
        wrPend_q  <= 1'b0;
      end else if (addrPhase) begin
        addr_q    <= haddr[`IPF_ADDR_W-1:0];
        wrPend_q  <= hwrite & (hsize == `IPF_HSIZE_WORD);
        rdPend_q  <= ~hwrite;
        hreadyout <= hwrite;
      end else begin
        wrPend_q <= 1'b0;
      end
    end
  end

endmodule

/* File: design/ipf_level_max.v */
`timescale 1ns/1ps
`include "ipf_map.vh"

module ipf_level_max #(
  parameter N = 5
) (
  input  wire [3*N-1:0] levels,
  input  wire [N-1:0]   requests,
  output reg  [2:0]     bestLevel,
  output reg  [2:0]     bestIndex,
  output reg            anyReq
);

  // ------------------------------------------------------------------
  // highest level wins; on a tie the lower index is kept
  // ------------------------------------------------------------------
  integer i;

  always @* begin
    bestLevel = `IPF_LVL_OFF;
    bestIndex = 3'h0;
    anyReq    = 1'b0;
    for (i = 0; i < N; i = i + 1) begin
      if (requests[i] && (levels[3*i +: 3] > bestLevel)) begin
        bestLevel = levels[3*i +: 3];
        bestIndex = i[2:0];
        anyReq    = 1'b1;
      end
    end
  end

endmodule

/* File: design/ipf_top.v */
// Implementation choices: register access over AHB-Lite and the register offsets.
`timescale 1ns/1ps
`include "ipf_map.vh"

module ipf_top (
  input  wire        ref_clk,
  input  wire        rst,
  // ahb-lite slave
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire        hready,
  input  wire [31:0] hwdata,
  output wire        hreadyout,
  output wire        hresp,
  output wire [31:0] hrdata,
  // raw source flags, same clock domain
  input  wire [4:0]  srcFlag,
  // priority fields toward arbitration
  output reg  [2:0]  adc1DonePriority_q,
  output reg  [2:0]  uart1TxPriority_q,
  output reg  [2:0]  changeNotifyPriority_q,
  output reg  [2:0]  i2c1MasterEventPriority_q,
  output reg  [2:0]  i2c1SlaveEventPriority_q,
  // derived state
  output reg  [4:0]  srcEnable_q,
  output reg  [4:0]  srcRequest_q,
  output reg  [2:0]  pendLevel_q,
  output reg  [2:0]  pendSource_q,
  output reg         cpuRequest_q
);

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  // a zero field parks the source: it can never reach the cpu
  function fieldOn;
    input [2:0] f;
    begin
      fieldOn = (f != `IPF_LVL_OFF);
    end
  endfunction

  function [2:0] fieldOf;
    input [15:0] word;
    input integer lsb;
    begin
      fieldOf = word[lsb +: 3];
    end
  endfunction

  // ------------------------------------------------------------------
  // bus front end
  // ------------------------------------------------------------------
  wire                   regWrEn;
  wire [`IPF_ADDR_W-1:0] regAddr;
  wire [15:0]            regWrData;
  reg  [15:0]            regRdData;

  ipf_ahb_slave u_bus (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .hready    (hready),
    .hwdata    (hwdata),
    .regRdData (regRdData),
    .hreadyout (hreadyout),
    .hresp     (hresp),
    .hrdata    (hrdata),
    .regWrEn   (regWrEn),
    .regAddr   (regAddr),
    .regWrData (regWrData)
  );

  wire wrTwo;
  wire wrThree;

  assign wrTwo   = regWrEn & (regAddr == `IPF_OFF_PRI_TWO);
  assign wrThree = regWrEn & (regAddr == `IPF_OFF_PRI_THREE);

  // ------------------------------------------------------------------
  // priority register two (low byte only)
  // ------------------------------------------------------------------
  // only the 3-bit fields are stored, so unused bits cannot be written
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      adc1DonePriority_q <= `IPF_PRI_RESET;
      uart1TxPriority_q  <= `IPF_PRI_RESET;
    end else if (wrTwo) begin
      adc1DonePriority_q <= fieldOf(regWrData, `IPF_ADC1_DONE_LSB);
      uart1TxPriority_q  <= fieldOf(regWrData, `IPF_UART1_TX_LSB);
    end
  end

  // ------------------------------------------------------------------
  // priority register three
  // ------------------------------------------------------------------
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      changeNotifyPriority_q    <= `IPF_PRI_RESET;
      i2c1MasterEventPriority_q <= `IPF_PRI_RESET;
      i2c1SlaveEventPriority_q  <= `IPF_PRI_RESET;
    end else if (wrThree) begin
      changeNotifyPriority_q    <= fieldOf(regWrData, `IPF_CHG_NOTE_LSB);
      i2c1MasterEventPriority_q <= fieldOf(regWrData, `IPF_I2C1_MST_LSB);
      i2c1SlaveEventPriority_q  <= fieldOf(regWrData, `IPF_I2C1_SLV_LSB);
    end
  end

  // ------------------------------------------------------------------
  // per-source gating and selection
  // ------------------------------------------------------------------
  wire [14:0] levelVec;
  wire [4:0]  enableVec;
  wire [4:0]  gatedReq;
  wire [2:0]  bestLevel;
  wire [2:0]  bestIndex;
  wire        anyReq;

  assign levelVec = {i2c1SlaveEventPriority_q,
                     i2c1MasterEventPriority_q,
                     changeNotifyPriority_q,
                     uart1TxPriority_q,
                     adc1DonePriority_q};

  assign enableVec = {fieldOn(i2c1SlaveEventPriority_q),
                      fieldOn(i2c1MasterEventPriority_q),
                      fieldOn(changeNotifyPriority_q),
                      fieldOn(uart1TxPriority_q),
                      fieldOn(adc1DonePriority_q)};

  assign gatedReq = srcFlag & enableVec;

  ipf_level_max #(
    .N (5)
  ) u_max (
    .levels    (levelVec),
    .requests  (gatedReq),
    .bestLevel (bestLevel),
    .bestIndex (bestIndex),
    .anyReq    (anyReq)
  );

  // registered so every output leaves from a flop; adds one cycle of lag
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      srcEnable_q  <= 5'h00;
      srcRequest_q <= 5'h00;
      pendLevel_q  <= `IPF_LVL_OFF;
      pendSource_q <= 3'h0;
      cpuRequest_q <= 1'b0;
    end else begin
      srcEnable_q  <= enableVec;
      srcRequest_q <= gatedReq;
      pendLevel_q  <= bestLevel;
      pendSource_q <= bestIndex;
      cpuRequest_q <= anyReq;
    end
  end

  // ------------------------------------------------------------------
  // read mux
  // ------------------------------------------------------------------
  always @* begin
    regRdData = 16'h0000;
    case (regAddr)
      `IPF_OFF_PRI_TWO: begin
        regRdData[`IPF_ADC1_DONE_LSB +: 3] = adc1DonePriority_q;
        regRdData[`IPF_UART1_TX_LSB +: 3]  = uart1TxPriority_q;
      end
      `IPF_OFF_PRI_THREE: begin
        // bits 15, 11:8, 7 and 3 stay zero
        regRdData[`IPF_CHG_NOTE_LSB +: 3] = changeNotifyPriority_q;
        regRdData[`IPF_I2C1_MST_LSB +: 3] = i2c1MasterEventPriority_q;
        regRdData[`IPF_I2C1_SLV_LSB +: 3] = i2c1SlaveEventPriority_q;
      end
      `IPF_OFF_STATUS: begin
        regRdData[`IPF_STAT_EN_LSB +: 5]  = srcEnable_q;
        regRdData[`IPF_STAT_SRC_LSB +: 3] = pendSource_q;
        regRdData[`IPF_STAT_LVL_LSB +: 3] = pendLevel_q;
        regRdData[`IPF_STAT_REQ_BIT]      = cpuRequest_q;
      end
      default: begin
        regRdData = 16'h0000;
      end
    endcase
  end

endmodule

/* File: verif/ipf_top_sva.sv */
`timescale 1ns/1ps

module ipf_top_sva (
  input wire logic        ref_clk,
  input wire logic        rst,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic        hready,
  input wire logic [31:0] hwdata,
  input wire logic        hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic [4:0]  srcFlag,
  input wire logic [2:0]  adc1DonePriority_q,
  input wire logic [2:0]  changeNotifyPriority_q,
  input wire logic [2:0]  i2c1MasterEventPriority_q,
  input wire logic [4:0]  srcRequest_q,
  input wire logic [2:0]  pendLevel_q,
  input wire logic [2:0]  pendSource_q,
  input wire logic        cpuRequest_q
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  wire logic take   = hsel && htrans[1] && hready;
  wire logic rdTake = take && !hwrite;
  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  chk_reset_fields: assert property ($fell(rst) |-> adc1DonePriority_q == 3'h4 &&
    changeNotifyPriority_q == 3'h4 && i2c1MasterEventPriority_q == 3'h4)
    else $error("field not at reset level after reset");
  chk_cn_write: assert property (take && hwrite && hsize == 3'h2 && haddr[7:0] == 8'h04
    |-> ##2 changeNotifyPriority_q == $past(hwdata[14:12])) else $error("cn field not written");
  chk_reg3_zero: assert property (rdTake && haddr[7:0] == 8'h04
    |-> ##2 (hrdata & 32'hFFFF8F88) == 32'h0) else $error("unused bit of reg three set");
  chk_read_wait: assert property (rdTake |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  chk_upper_zero: assert property (hrdata[31:16] == 16'h0)
    else $error("read data upper half not zero");
  chk_adc_off: assert property ((adc1DonePriority_q == 3'h0)[*3] |-> !srcRequest_q[0])
    else $error("disabled adc source requests");
  chk_req_cause: assert property (srcRequest_q[0] |-> $past(srcFlag[0]))
    else $error("adc request without flag");
  chk_idle_pend: assert property (!cpuRequest_q |->
    pendLevel_q == 3'h0 && pendSource_q == 3'h0) else $error("pending level without request");
  chk_cpu_level: assert property (cpuRequest_q |-> pendLevel_q != 3'h0)
    else $error("request at level zero");
endmodule

bind ipf_top ipf_top_sva u_ipf_top_sva (.ref_clk, .rst, .hsel, .haddr, .htrans, .hwrite,
  .hsize, .hready, .hwdata, .hreadyout, .hrdata, .srcFlag, .adc1DonePriority_q,
  .changeNotifyPriority_q, .i2c1MasterEventPriority_q, .srcRequest_q, .pendLevel_q,
  .pendSource_q, .cpuRequest_q);

/* File: verif/ipf_tb_top.sv */
`timescale 1ns/1ps

module ipf_tb_top;
  logic        ref_clk;
  logic        rst;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic [4:0]  srcFlag;
  wire         hreadyout;
  wire         hresp;
  wire  [31:0] hrdata;
  wire  [2:0]  adc1DonePriority_q, uart1TxPriority_q, changeNotifyPriority_q;
  wire  [2:0]  i2c1MasterEventPriority_q, i2c1SlaveEventPriority_q;
  wire  [4:0]  srcEnable_q, srcRequest_q;
  wire  [2:0]  pendLevel_q, pendSource_q;
  wire         cpuRequest_q;
  int          miscompares;
  int          nChecks;
  logic [31:0] rdData;

  ipf_top u_ipf_top (.ref_clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hready(hreadyout), .hwdata, .hreadyout, .hresp, .hrdata, .srcFlag, .adc1DonePriority_q,
    .uart1TxPriority_q, .changeNotifyPriority_q, .i2c1MasterEventPriority_q,
    .i2c1SlaveEventPriority_q, .srcEnable_q, .srcRequest_q, .pendLevel_q, .pendSource_q,
    .cpuRequest_q);

  initial begin
    ref_clk = 1'h0;
    forever #50 ref_clk = ~ref_clk;
  end

  // ------------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------------
  task results;
    if (miscompares == 0 && nChecks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    nChecks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // entered just after a rising edge; two phases, each waits for hready
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [2:0] sz);
    int i;
    int n;
    hsel   <= 1'h1;
    haddr  <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    hsize  <= sz;
    for (i = 0; i < 2; i++) begin
      n = 0;
      do begin
        @(posedge ref_clk);
        n++;
      end while (hreadyout !== 1'h1 && n < 16);
      if (hreadyout !== 1'h1) begin
        miscompares++;
        results;
      end
      if (i == 0) begin
        htrans <= 2'h0;
        hwdata <= d;
      end
    end
    rdData = hrdata;
  endtask

  task rd(input logic [7:0] a, input logic [31:0] exp);
    bus(1'h0, a, 32'h0, 3'h2);
    chk(rdData, exp);
    chk({31'h0, hresp}, 32'h0);
  endtask

  // enable, request and pending state are all registered and lag the field by one edge
  task settle;
    repeat (3) @(posedge ref_clk);
  endtask

  // ------------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------------
  task tReset;
    chk({17'h0, adc1DonePriority_q, uart1TxPriority_q, changeNotifyPriority_q,
      i2c1MasterEventPriority_q, i2c1SlaveEventPriority_q}, 32'h4924);
    rd(8'h00, 32'h0044);
    rd(8'h04, 32'h4044);
  endtask

  task tReg3;
    bus(1'h1, 8'h04, 32'hFFFF_FFFF, 3'h2);
    rd(8'h04, 32'h7077);
    chk({23'h0, changeNotifyPriority_q, i2c1MasterEventPriority_q,
      i2c1SlaveEventPriority_q}, 32'h1FF);
    bus(1'h1, 8'h04, 32'h0, 3'h0);
    rd(8'h04, 32'h7077);
    bus(1'h1, 8'h04, 32'h8F88, 3'h2);
    rd(8'h04, 32'h0000);
    bus(1'h1, 8'h0C, 32'hFFFF, 3'h2);
    rd(8'h0C, 32'h0000);
  endtask

  task tAdc;
    bus(1'h1, 8'h00, 32'hFFFF, 3'h2);
    rd(8'h00, 32'h0077);
    bus(1'h1, 8'h00, 32'h0070, 3'h2);
    srcFlag <= 5'h03;
    settle;
    chk({21'h0, srcRequest_q, pendLevel_q, pendSource_q}, {21'h0, 5'h01, 3'h7, 3'h0});
    bus(1'h1, 8'h00, 32'h0005, 3'h2);
    settle;
    chk({21'h0, srcRequest_q, pendLevel_q, pendSource_q}, {21'h0, 5'h02, 3'h5, 3'h1});
    srcFlag <= 5'h00;
  endtask

  task tLevels;
    int l;
    // previous scenario drove srcFlag in this time step
    @(posedge ref_clk);
    srcFlag <= 5'h04;
    for (l = 0; l < 8; l++) begin
      bus(1'h1, 8'h04, {17'h0, l[2:0], 12'h000}, 3'h2);
      settle;
      chk({25'h0, cpuRequest_q, pendLevel_q, pendSource_q},
        (l == 0) ? 32'h0 : {25'h0, 1'h1, l[2:0], 3'h2});
    end
    // equal levels: lower source index must win
    bus(1'h1, 8'h04, 32'h5050, 3'h2);
    srcFlag <= 5'h0C;
    settle;
    chk({25'h0, cpuRequest_q, pendLevel_q, pendSource_q}, {25'h0, 1'h1, 3'h5, 3'h2});
    chk({27'h0, srcEnable_q}, 32'h0000000E);
    // status is read-only: a write there must not reach register two
    bus(1'h1, 8'h08, 32'hFFFF, 3'h2);
    rd(8'h08, 32'hD20E);
    rd(8'h00, 32'h0005);
    srcFlag <= 5'h00;
  endtask

  initial begin
    rst         = 1'h1;
    hsel        = 1'h0;
    haddr       = 32'h0;
    htrans      = 2'h0;
    hwrite      = 1'h0;
    hsize       = 3'h2;
    hwdata      = 32'h0;
    srcFlag     = 5'h00;
    miscompares = 0;
    nChecks     = 0;
    repeat (8) @(posedge ref_clk);
    rst <= 1'h0;
    @(posedge ref_clk);
    tReset;
    tReg3;
    tAdc;
    tLevels;
    results;
  end
endmodule
